// ### bench/coia_props.sv
// port assertions of the counter access block
`timescale 1ns/1ns
module coia_props
	import coia_pkg::*;
#(
	parameter int LINKS = NUM_LINKS
)(
	input  wire logic                   CLK_I,
	input  wire logic                   RST_B_I,
	input  wire coia_reg_req_type       REG_REQ_I,
	input  wire logic [15:0]            REG_RDATA_O,
	input  wire logic                   REG_RVALID_O,
	input  wire logic [LINKS-1:0][15:0] OVF_EVENT_I,
	input  wire coia_cnt_cmd_type       CNT_CMD_O,
	input  wire logic                   CNT_CMD_VALID_O,
	input  wire logic                   CNT_ACK_I,
	input  wire logic [31:0]            CNT_RD_DATA_I,
	input  wire logic                   IRQ_B_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	////////////////////////////////////////////////////////////////
	rd_answer_a: assert property (REG_REQ_I.rd |=> REG_RVALID_O)
		else $error("read not answered");
	cmd_cause_a: assert property (CNT_CMD_VALID_O |-> $past(REG_REQ_I.wr)
		&& $past(REG_REQ_I.addr) == OFS_XFER_CMD && $past(REG_REQ_I.wdata[1:0]) != 2'h3)
		else $error("command without write");
	cmd_fields_a: assert property (CNT_CMD_VALID_O |-> CNT_CMD_O.op == $past(REG_REQ_I.wdata[1:0])
		&& CNT_CMD_O.to_cpu == $past(REG_REQ_I.wdata[2]))
		else $error("command fields wrong");
	cmd_single_a: assert property (CNT_CMD_VALID_O |=> !CNT_CMD_VALID_O)
		else $error("command pulse too long");
	irq_fall_a: assert property ($fell(IRQ_B_O) |-> $past(REG_REQ_I.wr) || $past(REG_REQ_I.wr, 2)
		|| $past(|OVF_EVENT_I) || $past(|OVF_EVENT_I, 2))
		else $error("interrupt without cause");
	irq_rise_a: assert property ($rose(IRQ_B_O) |-> $past(REG_REQ_I.wr) || $past(REG_REQ_I.wr, 2))
		else $error("interrupt dropped without write");
	upper_zero_a: assert property (REG_RVALID_O && $past(REG_REQ_I.addr) == OFS_CNT_UPPER
		|-> REG_RDATA_O[15:8] == 8'h00) else $error("upper byte high bits set");
	stat_zero_a: assert property (REG_RVALID_O && $past(REG_REQ_I.addr[11:4]) == 8'h41
		|-> (REG_RDATA_O & ~FLAG_MASK) == 16'h0000) else $error("reserved flag bits set");
	sel_zero_a: assert property (REG_RVALID_O && $past(REG_REQ_I.addr) == OFS_CNT_SELECT
		|-> REG_RDATA_O[15:9] == 7'h00) else $error("select high bits set");
endmodule
////////////////////////////////////////////////////////////////
bind coia_top coia_props #(.LINKS(LINKS)) u_props (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
	.REG_REQ_I(REG_REQ_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
	.OVF_EVENT_I(OVF_EVENT_I), .CNT_CMD_O(CNT_CMD_O), .CNT_CMD_VALID_O(CNT_CMD_VALID_O),
	.CNT_ACK_I(CNT_ACK_I), .CNT_RD_DATA_I(CNT_RD_DATA_I), .IRQ_B_O(IRQ_B_O));

// ### bench/coia_top_tb.sv
// self-checking bench of the counter access block
`timescale 1ns/1ns
module coia_top_tb
	import coia_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst_b = 1'b0;
	coia_reg_req_type  req = '0;
	logic [15:0][15:0] ev = '0;
	logic              ack = 1'b0;
	logic [31:0]       rdd = 32'h00000000;
	logic [15:0]       rdata, v, m;
	logic              rvalid, cvalid, irq_b;
	coia_cnt_cmd_type  cmd;
	logic [31:0]       d;
	logic [11:0]       sa;
	integer            seed = 32'h8415bfb3;
	int                errors = 0, n_checks = 0, l, k;
	logic [11:0]       offs [7] = '{12'h430, 12'h431, 12'h432, 12'h433, 12'h434, 12'h455, 12'h410};
	logic [3:0]        kinds [9] = '{4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6, 4'h3, 4'h2, 4'h1};
	always #5 clk = ~clk;
	coia_top DUT (.CLK_I(clk), .RST_B_I(rst_b), .REG_REQ_I(req), .REG_RDATA_O(rdata),
		.REG_RVALID_O(rvalid), .OVF_EVENT_I(ev), .CNT_CMD_O(cmd), .CNT_CMD_VALID_O(cvalid),
		.CNT_ACK_I(ack), .CNT_RD_DATA_I(rdd), .IRQ_B_O(irq_b));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [39:0] seen, input logic [39:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] dt);
		req = '{1'b1, 1'b0, a, dt};
		@(posedge clk);
		req.wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [11:0] a);
		req = '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		v = rdata;
		chk("rvalid", rvalid, 1);
	endtask
	task automatic pulse(input int ln, input int b);
		ev[ln][b] = 1'b1;
		@(posedge clk);
		ev[ln][b] <= 1'b0;
		@(negedge clk);
	endtask
	function automatic logic [15:0] fexp(input int b);
		return FLAG_MASK & (16'h0001 << b);
	endfunction
	task automatic tally_and_finish();
		if (errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		foreach (offs[i]) begin
			rd(offs[i]);
			chk("reset value", v, 0);
		end
		rd(OFS_XFER_CMD);
		chk("idle done", v, 16'h0080);
		rd(12'h7ff);
		chk("unmapped", v, 0);
		// every bit position, reserved ones too
		for (k = 0; k < 16; k++) begin
			l = $unsigned($random(seed)) % 16;
			sa = OFS_OVF_STAT_BASE + 12'(l);
			pulse(l, k);
			rd(sa);
			chk("flag set", v, fexp(k));
			wr(sa, FLAG_MASK);
			rd(sa);
			chk("flag kept", v, fexp(k));
			wr(sa, 16'h0000);
			rd(sa);
			chk("flag cleared", v, 0);
		end
		// interrupt path of one link
		l = $unsigned($random(seed)) % 16;
		m = 16'h0001 << l;
		sa = OFS_OVF_STAT_BASE + 12'(l);
		pulse(l, BIT_TX_ALL);
		wr(OFS_MASTER_EN, 16'hffff);
		repeat (2) @(negedge clk);
		chk("irq gated", irq_b, 1);
		wr(OFS_OVF_EN, m);
		repeat (2) @(negedge clk);
		chk("irq low", irq_b, 0);
		wr(OFS_MASTER_STAT, 16'h0000);
		rd(OFS_MASTER_STAT);
		chk("master status", v, m);
		wr(OFS_MASTER_EN, ~m);
		repeat (2) @(negedge clk);
		chk("irq masked", irq_b, 1);
		wr(OFS_MASTER_EN, m);
		repeat (2) @(negedge clk);
		chk("irq again", irq_b, 0);
		wr(sa, 16'h0000);
		repeat (2) @(negedge clk);
		chk("irq cleared", irq_b, 1);
		// counter reads of every kind
		foreach (kinds[i]) begin
			l = $unsigned($random(seed)) % 16;
			d = $random(seed);
			wr(OFS_CNT_SELECT, {7'h00, kinds[i], 5'(l)});
			wr(OFS_XFER_CMD, 16'h0005);
			chk("cmd", {cvalid, cmd.op, cmd.to_cpu, cmd.kind, cmd.link},
				{1'b1, 2'h1, 1'b1, kinds[i], 5'(l)});
			rd(OFS_XFER_CMD);
			chk("pending", v, 16'h0004);
			rdd = d;
			ack = 1'b1;
			@(negedge clk);
			ack = 1'b0;
			rdd = ~d;
			rd(OFS_CNT_UPPER);
			chk("byte 3", v, {8'h00, d[31:24]});
			rd(OFS_CNT_MIDDLE);
			chk("bytes 2 1", v, d[23:8]);
			rd(OFS_XFER_CMD);
			chk("done", v, 16'h0084);
		end
		// counter load, with a refused command while busy
		d = $random(seed);
		wr(OFS_CNT_UPPER, {8'h00, d[31:24]});
		wr(OFS_CNT_MIDDLE, d[23:8]);
		wr(OFS_XFER_CMD, 16'h0001);
		chk("load", {cvalid, cmd.to_cpu, cmd.data}, {2'b10, d[31:8], 8'h00});
		wr(OFS_XFER_CMD, 16'h0001);
		chk("busy refuse", cvalid, 0);
		ack = 1'b1;
		@(negedge clk);
		ack = 1'b0;
		wr(OFS_XFER_CMD, 16'h000b);
		chk("op 11 refuse", cvalid, 0);
		wr(OFS_XFER_CMD, 16'h000a);
		chk("irq en cmd", {cvalid, cmd.op, cmd.en_val, cmd.to_cpu}, 5'b11010);
		ack = 1'b1;
		@(negedge clk);
		ack = 1'b0;
		rd(OFS_XFER_CMD);
		chk("done after irq en", v, 16'h0080);
		tally_and_finish();
	end
endmodule

// ### src/coia_cnt_access.sv
// select, byte holding and transfer command logic for indirect counter access
`timescale 1ns/1ns
module coia_cnt_access
	import coia_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             wr_upper_i,
	input  wire logic             wr_middle_i,
	input  wire logic             wr_select_i,
	input  wire logic             wr_cmd_i,
	input  wire logic [15:0]      wdata_i,
	input  wire logic             ack_i,
	input  wire logic [31:0]      rd_data_i,
	output logic      [15:0]      select_o,
	output logic      [31:0]      snap_o,
	output logic                  done_o,
	output logic                  to_cpu_o,
	output coia_cnt_cmd_type      cmd_o,
	output logic                  cmd_valid_o
);

	typedef struct packed {
		logic [7:0]          upper;
		logic [15:0]         middle;
		logic [3:0]          kind;
		logic [4:0]          link;
		logic [31:0]         snap;
		logic                to_cpu;
		coia_xfer_state_type st;
		coia_cnt_cmd_type    cmd;
		logic                cmd_valid;
	} coia_ca_state_type;

	coia_ca_state_type s_q;
	coia_ca_state_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.cmd_valid = 1'b0;
		if (wr_upper_i) begin
			s_d.upper = wdata_i[7:0];                                  // [R8]
		end
		if (wr_middle_i) begin
			s_d.middle = wdata_i;                                      // [R8] [R9]
		end
		if (wr_select_i) begin
			s_d.kind = wdata_i[SEL_KIND_LSB +: 4];                     // [R10]
			s_d.link = wdata_i[SEL_LINK_LSB +: 5];                     // [R11]
		end
		case (s_q.st)
			XF_IDLE: begin
				if (wr_cmd_i && (wdata_i[CMD_OP_LSB +: 2] != XOP_UNUSED)) begin
					s_d.to_cpu     = wdata_i[CMD_DIR_BIT];             // [R17]
					s_d.cmd.op     = coia_xop_type'(wdata_i[CMD_OP_LSB +: 2]);
					s_d.cmd.to_cpu = wdata_i[CMD_DIR_BIT];
					s_d.cmd.en_val = wdata_i[CMD_EN_VAL_BIT];
					s_d.cmd.kind   = coia_cnt_kind_type'(s_q.kind);
					s_d.cmd.link   = s_q.link;
					s_d.cmd.data   = {s_q.upper, s_q.middle, 8'h00};   // [R8]
					s_d.cmd_valid  = 1'b1;
					s_d.st         = XF_BUSY;
				end
			end
			XF_BUSY: begin
				if (ack_i) begin
					if (s_q.cmd.to_cpu && (s_q.cmd.op == XOP_COUNTER)) begin
						s_d.snap = rd_data_i;                          // [R7] [R9]
					end
					s_d.st = XF_IDLE;
				end
			end
			default: begin
				s_d.st = XF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s_q.upper     <= RST_CNT_UPPER[7:0];
			s_q.middle    <= RST_CNT_MIDDLE;
			s_q.kind      <= RST_CNT_SELECT[SEL_KIND_LSB +: 4];
			s_q.link      <= RST_CNT_SELECT[SEL_LINK_LSB +: 5];
			s_q.snap      <= 32'h0000_0000;
			s_q.to_cpu    <= 1'b0;
			s_q.st        <= XF_IDLE;
			s_q.cmd       <= '0;
			s_q.cmd_valid <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign select_o    = {7'h00, s_q.kind, s_q.link};
	assign snap_o      = s_q.snap;
	assign done_o      = (s_q.st == XF_IDLE);
	assign to_cpu_o    = s_q.to_cpu;
	assign cmd_o       = s_q.cmd;
	assign cmd_valid_o = s_q.cmd_valid;

endmodule

// ### src/coia_link_flags.sv
// latched overflow flags and interrupt request of one link
`timescale 1ns/1ns
module coia_link_flags
	import coia_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic [15:0] event_i,
	input  wire logic        wr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        ovf_en_i,
	output logic      [15:0] flags_o,
	output logic             irq_req_o
);

	typedef struct packed {
		logic [15:0] flags;
	} coia_lf_state_type;

	coia_lf_state_type s_q;
	coia_lf_state_type s_d;
	logic [15:0]       clr;

	always_comb begin
		s_d = s_q;
		clr = wr_i ? (~wdata_i & FLAG_MASK) : 16'h0000;              // [R5] [R20]
		// set wins over a clear in the same cycle
		s_d.flags = ((s_q.flags & ~clr) | (event_i & FLAG_MASK)) & FLAG_MASK; // [R1] [R2] [R3] [R4] [R6]
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s_q.flags <= RST_OVF_STAT;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags_o   = s_q.flags;
	assign irq_req_o = (|s_q.flags) & ovf_en_i;                     // [R15] [R19]

endmodule

// ### src/coia_pkg.sv
// constants and types of the counter overflow interrupt and counter access block
// Notes on behaviour
// R1 - receive fifo overflow sets flag bit 12
// R2 - utopia input counter overflows set bits 11..8
// R3 - transmit tdm overflows set bits 7, 6
// R4 - receive tdm overflows set bits 3, 2, 1
// R5 - flags stay set until software writes zero
// R6 - bits 15:13 read zero; 5,4,0 written zero
// R7 - upper byte register reads counter byte 3
// R8 - written byte registers feed counter load
// R9 - middle register reads bytes 2 and 1
// R10 - select bits 8:5 choose counter type
// R11 - select bits 4:0 choose link 15..0
// R12 - software writes only valid select codes
// R13 - enabled link request drives interrupt pin low
// R14 - disabled link leaves interrupt pin alone
// R15 - overflow enable gates each link's flags
// R16 - receive line clock must keep running
// R17 - command 01 starts counter transfer, direction bit
// R18 - master status unlatched per link, writes ignored
// R19 - link request is or of enabled flags
// R20 - writing one leaves a flag unchanged
package coia_pkg;

	localparam int          NUM_LINKS          = 16;
	localparam int          ADDR_W             = 12;
	localparam int          DATA_W             = 16;

	localparam logic [11:0] OFS_XFER_CMD       = 12'h40f;
	localparam logic [11:0] OFS_OVF_STAT_BASE  = 12'h410;
	localparam logic [11:0] OFS_CNT_UPPER      = 12'h430;
	localparam logic [11:0] OFS_CNT_MIDDLE     = 12'h431;
	localparam logic [11:0] OFS_CNT_SELECT     = 12'h432;
	localparam logic [11:0] OFS_MASTER_EN      = 12'h433;
	localparam logic [11:0] OFS_OVF_EN         = 12'h434;
	localparam logic [11:0] OFS_MASTER_STAT    = 12'h455;

	localparam logic [15:0] RST_MASTER_EN      = 16'h0000;
	localparam logic [15:0] RST_OVF_EN         = 16'h0000;
	localparam logic [15:0] RST_OVF_STAT       = 16'h0000;
	localparam logic [15:0] RST_CNT_UPPER      = 16'h0000;
	localparam logic [15:0] RST_CNT_MIDDLE     = 16'h0000;
	localparam logic [15:0] RST_CNT_SELECT     = 16'h0000;

	// flag positions
	localparam int          BIT_RX_FIFO        = 12;
	localparam int          BIT_UI_ALL         = 11;
	localparam int          BIT_UI_IDLE        = 10;
	localparam int          BIT_UI_UNASSIGNED  = 9;
	localparam int          BIT_UI_HEC         = 8;
	localparam int          BIT_TX_ALL         = 7;
	localparam int          BIT_TX_IDLE        = 6;
	localparam int          BIT_RX_ALL         = 3;
	localparam int          BIT_RX_IDLE        = 2;
	localparam int          BIT_RX_HEC         = 1;
	localparam logic [15:0] FLAG_MASK          = 16'h1fce;

	// select register fields
	localparam int          SEL_KIND_LSB       = 5;
	localparam int          SEL_LINK_LSB       = 0;

	// transfer command register fields
	localparam int          CMD_OP_LSB         = 0;
	localparam int          CMD_DIR_BIT        = 2;
	localparam int          CMD_EN_VAL_BIT     = 3;
	localparam int          CMD_DONE_BIT       = 7;

	typedef enum logic [1:0] {
		XOP_INIT_ALL = 2'h0,
		XOP_COUNTER  = 2'h1,
		XOP_IRQ_EN   = 2'h2,
		XOP_UNUSED   = 2'h3
	} coia_xop_type;

	typedef enum logic [3:0] {
		CK_UI_ALL    = 4'hb,
		CK_UI_IDLE   = 4'ha,
		CK_UI_UNAS   = 4'h9,
		CK_UI_HEC    = 4'h8,
		CK_TX_ALL    = 4'h7,
		CK_TX_IDLE   = 4'h6,
		CK_RX_ALL    = 4'h3,
		CK_RX_IDLE   = 4'h2,
		CK_RX_HEC    = 4'h1
	} coia_cnt_kind_type;

	typedef enum logic [1:0] {
		XF_IDLE = 2'b01,
		XF_BUSY = 2'b10
	} coia_xfer_state_type;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [11:0]       addr;
		logic [15:0]       wdata;
	} coia_reg_req_type;

	typedef struct packed {
		coia_xop_type      op;
		logic              to_cpu;
		logic              en_val;
		coia_cnt_kind_type kind;
		logic [4:0]        link;
		logic [31:0]       data;
	} coia_cnt_cmd_type;

endpackage

// ### src/coia_top.sv
// register port, per-link overflow flags and interrupt pin of the counter access block
`timescale 1ns/1ns
module coia_top
	import coia_pkg::*;
#(
	parameter int LINKS = NUM_LINKS
)(
	input  wire logic                        CLK_I,
	input  wire logic                        RST_B_I,
	input  wire coia_reg_req_type            REG_REQ_I,
	output logic      [15:0]                 REG_RDATA_O,
	output logic                             REG_RVALID_O,
	input  wire logic [LINKS-1:0][15:0]      OVF_EVENT_I,
	output coia_cnt_cmd_type                 CNT_CMD_O,
	output logic                             CNT_CMD_VALID_O,
	input  wire logic                        CNT_ACK_I,
	input  wire logic [31:0]                 CNT_RD_DATA_I,
	output logic                             IRQ_B_O
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [15:0] master_en;
		logic [15:0] ovf_en;
		logic [15:0] rdata;
		logic        rvalid;
		logic        irq_b;
	} coia_top_state_type;

	coia_top_state_type      s_q;
	coia_top_state_type      s_d;

	logic [LINKS-1:0][15:0]  flags;
	logic [15:0]             master_stat;
	logic [LINKS-1:0]        link_wr;
	logic                    in_stat_range;
	logic [3:0]              stat_idx;
	logic [15:0]             select_val;
	logic [31:0]             snap_val;
	logic                    xfer_done;
	logic                    xfer_to_cpu;

	////////////////////////////////////////////////////////////////////////////////
	// address decode

	assign in_stat_range = (REG_REQ_I.addr[11:4] == OFS_OVF_STAT_BASE[11:4]);
	assign stat_idx      = REG_REQ_I.addr[3:0];

	////////////////////////////////////////////////////////////////////////////////
	// per-link flags

	genvar g;
	generate
		for (g = 0; g < LINKS; g++) begin : g_link
			assign link_wr[g] = REG_REQ_I.wr && in_stat_range && (stat_idx == 4'(g));
			coia_link_flags u_flags (
				.clk_i     (CLK_I),
				.rst_b_i   (RST_B_I),
				.event_i   (OVF_EVENT_I[g]),
				.wr_i      (link_wr[g]),
				.wdata_i   (REG_REQ_I.wdata),
				.ovf_en_i  (s_q.ovf_en[g]),
				.flags_o   (flags[g]),
				.irq_req_o (master_stat[g])                         // [R18]
			);
		end
		for (g = LINKS; g < 16; g++) begin : g_absent
			assign master_stat[g] = 1'b0;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// counter access

	coia_cnt_access u_cnt (
		.clk_i       (CLK_I),
		.rst_b_i     (RST_B_I),
		.wr_upper_i  (REG_REQ_I.wr && (REG_REQ_I.addr == OFS_CNT_UPPER)),
		.wr_middle_i (REG_REQ_I.wr && (REG_REQ_I.addr == OFS_CNT_MIDDLE)),
		.wr_select_i (REG_REQ_I.wr && (REG_REQ_I.addr == OFS_CNT_SELECT)),
		.wr_cmd_i    (REG_REQ_I.wr && (REG_REQ_I.addr == OFS_XFER_CMD)),
		.wdata_i     (REG_REQ_I.wdata),
		.ack_i       (CNT_ACK_I),
		.rd_data_i   (CNT_RD_DATA_I),
		.select_o    (select_val),
		.snap_o      (snap_val),
		.done_o      (xfer_done),
		.to_cpu_o    (xfer_to_cpu),
		.cmd_o       (CNT_CMD_O),
		.cmd_valid_o (CNT_CMD_VALID_O)
	);

	////////////////////////////////////////////////////////////////////////////////
	// registers, read mux, interrupt pin

	always_comb begin
		s_d        = s_q;
		s_d.rvalid = REG_REQ_I.rd;
		if (REG_REQ_I.wr) begin
			if (REG_REQ_I.addr == OFS_MASTER_EN) begin
				s_d.master_en = REG_REQ_I.wdata;
			end
			if (REG_REQ_I.addr == OFS_OVF_EN) begin
				s_d.ovf_en = REG_REQ_I.wdata;                         // [R15]
			end
		end
		if (REG_REQ_I.rd) begin
			s_d.rdata = 16'h0000;
			if (in_stat_range) begin
				if (int'(stat_idx) < LINKS) begin
					s_d.rdata = flags[stat_idx] & FLAG_MASK;          // [R6]
				end
			end else begin
				case (REG_REQ_I.addr)
					OFS_XFER_CMD: begin
						s_d.rdata[CMD_DONE_BIT] = xfer_done;           // [R17]
						s_d.rdata[CMD_DIR_BIT]  = xfer_to_cpu;
					end
					OFS_CNT_UPPER: begin
						s_d.rdata = {8'h00, snap_val[31:24]};         // [R7]
					end
					OFS_CNT_MIDDLE: begin
						s_d.rdata = snap_val[23:8];                    // [R9]
					end
					OFS_CNT_SELECT: begin
						s_d.rdata = select_val;
					end
					OFS_MASTER_EN: begin
						s_d.rdata = s_q.master_en;
					end
					OFS_OVF_EN: begin
						s_d.rdata = s_q.ovf_en;
					end
					OFS_MASTER_STAT: begin
						s_d.rdata = master_stat;                       // [R18]
					end
					default: begin
						s_d.rdata = 16'h0000;
					end
				endcase
			end
		end
		s_d.irq_b = ~(|(master_stat & s_q.master_en));                // [R13] [R14]
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			s_q.master_en <= RST_MASTER_EN;
			s_q.ovf_en    <= RST_OVF_EN;
			s_q.rdata     <= 16'h0000;
			s_q.rvalid    <= 1'b0;
			s_q.irq_b     <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign REG_RDATA_O  = s_q.rdata;
	assign REG_RVALID_O = s_q.rvalid;
	assign IRQ_B_O      = s_q.irq_b;

endmodule
